// ---- rtl/adcctl_top.sv ----
// Notes on behaviour
// - Sample-hold length from bits 7-4 codes; other codes reserved.
// - Conversion clock is source clock divided by 1, 2, 4, 8 or 16.
// - A conversion lasts at least 46 conversion clocks with sample-hold.
// - Done flag reads 0 before or during the first conversion after start, 1 once finished.
// - Reading the mode register clears the done flag.
// - Busy flag is 1 while converting, 0 when stopped.
// - Repeat bit 0 gives one conversion, 1 converts continuously.
// - Scan bit selects fixed channel or channel range scanning.
// - Writing start 1 launches conversion; 0 does nothing; reads 0.
// - Fixed repeat interrupt every 1, 4 or 8 conversions.
// - Interval field counts only with repeat 1 and scan 0.
module adcctl_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic sample_hold_active,
  output logic sar_active,
  output logic conversion_end,
  output logic scan_mode,
  output logic repeat_mode,
  output logic reference_power_on
);

  typedef struct packed {
    adcctl_pkg::adcctl_state_t state;
    logic [9:0] phase_cnt;
    logic [3:0] sh_sel;
    logic [2:0] div_sel;
    logic [3:0] run_sh_sel;
    logic [2:0] run_div_sel;
    logic [7:0] accuracy_trim_value;
    logic [1:0] interval;
    logic repeat_en;
    logic scan_en;
    logic ref_on;
    logic normal_done_flag;
    logic normal_busy_flag;
    logic irq_status;
    logic irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic end_pulse;
    logic sh_out;
    logic sar_out;
  } adcctl_regs_t;

  adcctl_regs_t s_q;
  adcctl_regs_t s_d;

  logic req;
  logic take;
  logic lane0;
  logic wr_hit;
  logic start_req;
  logic tick;
  logic finish;
  logic fire;
  logic fixed_repeat;
  logic [9:0] sh_len;
  logic launch;
  logic rd_mode0;
  logic rd_status;
  logic sh_last;
  logic sar_last;

  // Address match against one register offset
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    return (addr == ofs);
  endfunction : addr_is

  // Readback word of one register, unmapped addresses read zero
  function automatic logic [31:0] read_word(input logic [7:0] addr, input adcctl_regs_t r);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      adcctl_pkg::OFS_CLOCK: begin
        w[adcctl_pkg::SH_MSB:adcctl_pkg::SH_LSB] = r.sh_sel;
        w[adcctl_pkg::DIV_MSB:adcctl_pkg::DIV_LSB] = r.div_sel;
      end
      adcctl_pkg::OFS_MODE0: begin
        w[adcctl_pkg::DONE_BIT] = r.normal_done_flag;
        w[adcctl_pkg::BUSY_BIT] = r.normal_busy_flag;
        w[adcctl_pkg::ITV_MSB:adcctl_pkg::ITV_LSB] = r.interval;
        w[adcctl_pkg::REPEAT_BIT] = r.repeat_en;
        w[adcctl_pkg::SCAN_BIT] = r.scan_en;
      end
      adcctl_pkg::OFS_MODE1: begin
        w[adcctl_pkg::REF_ON_BIT] = r.ref_on;
      end
      adcctl_pkg::OFS_TRIM: begin
        w[adcctl_pkg::TRIM_MSB:adcctl_pkg::TRIM_LSB] = r.accuracy_trim_value;
      end
      adcctl_pkg::OFS_IRQ_STATUS: begin
        w[adcctl_pkg::IRQ_CONV_BIT] = r.irq_status;
      end
      adcctl_pkg::OFS_IRQ_MASK: begin
        w[adcctl_pkg::IRQ_CONV_BIT] = r.irq_mask;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : read_word

  // Bus request decode
  assign req = avs_read || avs_write;
  assign take = req && !s_q.ack;
  assign lane0 = avs_byteenable[0];
  assign wr_hit = avs_write && s_q.ack && lane0;
  assign start_req = wr_hit && addr_is(avs_address, adcctl_pkg::OFS_MODE0) &&
                     avs_writedata[adcctl_pkg::START_BIT];
  assign fixed_repeat = s_q.repeat_en && !s_q.scan_en;

  // Read strobes at the capture edge
  assign rd_mode0 = take && avs_read && addr_is(avs_address, adcctl_pkg::OFS_MODE0);
  assign rd_status = take && avs_read && addr_is(avs_address, adcctl_pkg::OFS_IRQ_STATUS);

  // Start only from idle, a start while busy is ignored
  assign launch = start_req && (s_q.state == adcctl_pkg::ADCCTL_IDLE);

  // Phase ends, timed by settings held since launch
  assign sh_len = adcctl_pkg::sh_clocks(s_q.run_sh_sel);
  assign sh_last = tick && (s_q.phase_cnt == sh_len - 10'h001);
  assign sar_last = tick && (s_q.phase_cnt == adcctl_pkg::SAR_CLOCKS - 10'h001);

  // Divided conversion clock, realigned on each launch
  adcctl_clkdiv u_clkdiv (
    .clock(clock),
    .reset(reset),
    .restart(launch),
    .div_sel(s_q.run_div_sel),
    .tick(tick)
  );

  // Interrupt interval in fixed-channel repeat mode
  adcctl_interval u_interval (
    .clock(clock),
    .reset(reset),
    .clear(launch),
    .done(finish),
    .enable(fixed_repeat),
    .interval(s_q.interval),
    .fire(fire)
  );

  // Last conversion clock of the approximation phase
  assign finish = (s_q.state == adcctl_pkg::ADCCTL_CONVERT) && sar_last;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.end_pulse = 1'b0;

    // One wait cycle, then the answer
    s_d.ack = take;
    if (take) begin
      s_d.rdata = read_word(avs_address, s_q);
    end

    // Register writes at the accepting edge
    if (wr_hit) begin
      case (avs_address)
        adcctl_pkg::OFS_CLOCK: begin
          s_d.sh_sel = avs_writedata[adcctl_pkg::SH_MSB:adcctl_pkg::SH_LSB];
          s_d.div_sel = avs_writedata[adcctl_pkg::DIV_MSB:adcctl_pkg::DIV_LSB];
        end
        adcctl_pkg::OFS_MODE0: begin
          s_d.interval = avs_writedata[adcctl_pkg::ITV_MSB:adcctl_pkg::ITV_LSB];
          s_d.repeat_en = avs_writedata[adcctl_pkg::REPEAT_BIT];
          s_d.scan_en = avs_writedata[adcctl_pkg::SCAN_BIT];
        end
        adcctl_pkg::OFS_MODE1: begin
          s_d.ref_on = avs_writedata[adcctl_pkg::REF_ON_BIT];
        end
        adcctl_pkg::OFS_TRIM: begin
          s_d.accuracy_trim_value = avs_writedata[adcctl_pkg::TRIM_MSB:adcctl_pkg::TRIM_LSB];
        end
        adcctl_pkg::OFS_IRQ_MASK: begin
          s_d.irq_mask = avs_writedata[adcctl_pkg::IRQ_CONV_BIT];
        end
        default: begin
          s_d.irq_mask = s_q.irq_mask;
        end
      endcase
    end

    // Read side effects at the capture edge
    if (rd_mode0) begin
      s_d.normal_done_flag = 1'b0;
    end
    if (rd_status) begin
      s_d.irq_status = 1'b0;
    end

    // Conversion sequencer
    unique case (s_q.state)
      adcctl_pkg::ADCCTL_IDLE: begin
        s_d.phase_cnt = 10'h000;
        if (launch) begin
          s_d.state = adcctl_pkg::ADCCTL_SAMPLE;
          // Settings frozen for the run, changes apply at next start
          s_d.run_sh_sel = s_q.sh_sel;
          s_d.run_div_sel = s_q.div_sel;
          s_d.normal_busy_flag = 1'b1;
          s_d.normal_done_flag = 1'b0;
        end
      end
      adcctl_pkg::ADCCTL_SAMPLE: begin
        if (tick) begin
          if (sh_last) begin
            s_d.state = adcctl_pkg::ADCCTL_CONVERT;
            s_d.phase_cnt = 10'h000;
          end else begin
            s_d.phase_cnt = s_q.phase_cnt + 10'h001;
          end
        end
      end
      adcctl_pkg::ADCCTL_CONVERT: begin
        if (finish) begin
          s_d.phase_cnt = 10'h000;
          s_d.end_pulse = 1'b1;
          s_d.normal_done_flag = 1'b1;
          if (s_q.repeat_en) begin
            s_d.state = adcctl_pkg::ADCCTL_SAMPLE;
          end else begin
            s_d.state = adcctl_pkg::ADCCTL_IDLE;
            s_d.normal_busy_flag = 1'b0;
          end
        end else if (tick) begin
          s_d.phase_cnt = s_q.phase_cnt + 10'h001;
        end
      end
    endcase

    // Interrupt event wins over a clearing read
    if (fire) begin
      s_d.irq_status = 1'b1;
    end

    // Registered phase indicators
    s_d.sh_out = (s_d.state == adcctl_pkg::ADCCTL_SAMPLE);
    s_d.sar_out = (s_d.state == adcctl_pkg::ADCCTL_CONVERT);
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
      s_q.state <= adcctl_pkg::ADCCTL_IDLE;
      s_q.sh_sel <= adcctl_pkg::SH_RESET;
      s_q.div_sel <= adcctl_pkg::DIV_RESET;
      s_q.run_sh_sel <= adcctl_pkg::SH_RESET;
      s_q.run_div_sel <= adcctl_pkg::DIV_RESET;
      s_q.accuracy_trim_value <= adcctl_pkg::TRIM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign avs_waitrequest = req && !s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign irq = s_q.irq_status && s_q.irq_mask;
  assign sample_hold_active = s_q.sh_out;
  assign sar_active = s_q.sar_out;
  assign conversion_end = s_q.end_pulse;
  assign scan_mode = s_q.scan_en;
  assign repeat_mode = s_q.repeat_en;
  assign reference_power_on = s_q.ref_on;

endmodule : adcctl_top

// ---- rtl/adcctl_pkg.sv ----
package adcctl_pkg;

  // Register byte offsets on the peripheral bus
  localparam logic [7:0] OFS_CLOCK = 8'h00;
  localparam logic [7:0] OFS_MODE0 = 8'h04;
  localparam logic [7:0] OFS_MODE1 = 8'h08;
  localparam logic [7:0] OFS_TRIM = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h60;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h64;

  // Conversion clock register fields
  localparam int SH_MSB = 7;
  localparam int SH_LSB = 4;
  localparam int DIV_MSB = 2;
  localparam int DIV_LSB = 0;
  localparam logic [3:0] SH_RESET = 4'h8;
  localparam logic [2:0] DIV_RESET = 3'h0;

  // Mode register fields
  localparam int DONE_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int ITV_MSB = 4;
  localparam int ITV_LSB = 3;
  localparam int REPEAT_BIT = 2;
  localparam int SCAN_BIT = 1;
  localparam int START_BIT = 0;

  // Reference supply control bit in the second mode register
  localparam int REF_ON_BIT = 7;

  // Accuracy trim field and interrupt bit layout
  localparam int TRIM_MSB = 7;
  localparam int TRIM_LSB = 0;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam int IRQ_CONV_BIT = 0;

  // Sample-hold codes
  localparam logic [3:0] SH_CODE_8 = 4'h8;
  localparam logic [3:0] SH_CODE_16 = 4'h9;
  localparam logic [3:0] SH_CODE_24 = 4'hA;
  localparam logic [3:0] SH_CODE_32 = 4'hB;
  localparam logic [3:0] SH_CODE_64 = 4'h3;
  localparam logic [3:0] SH_CODE_128 = 4'hC;
  localparam logic [3:0] SH_CODE_512 = 4'hD;

  // Divider codes
  localparam logic [2:0] DIV_CODE_1 = 3'h0;
  localparam logic [2:0] DIV_CODE_2 = 3'h1;
  localparam logic [2:0] DIV_CODE_4 = 3'h2;
  localparam logic [2:0] DIV_CODE_8 = 3'h3;
  localparam logic [2:0] DIV_CODE_16 = 3'h4;

  // Interrupt interval codes
  localparam logic [1:0] ITV_EVERY_1 = 2'h0;
  localparam logic [1:0] ITV_EVERY_4 = 2'h1;
  localparam logic [1:0] ITV_EVERY_8 = 2'h2;

  // Conversion timing in conversion clocks
  localparam int TOTAL_MIN_CLOCKS = 46;
  localparam int SH_MIN_CLOCKS = 8;
  localparam logic [9:0] SAR_CLOCKS = 10'(TOTAL_MIN_CLOCKS - SH_MIN_CLOCKS);

  typedef enum logic [1:0] {
    ADCCTL_IDLE,
    ADCCTL_SAMPLE,
    ADCCTL_CONVERT
  } adcctl_state_t;

  // Sample-hold length in conversion clocks, reserved codes take the shortest
  function automatic logic [9:0] sh_clocks(input logic [3:0] code);
    case (code)
      SH_CODE_16: sh_clocks = 10'h010;
      SH_CODE_24: sh_clocks = 10'h018;
      SH_CODE_32: sh_clocks = 10'h020;
      SH_CODE_64: sh_clocks = 10'h040;
      SH_CODE_128: sh_clocks = 10'h080;
      SH_CODE_512: sh_clocks = 10'h200;
      default: sh_clocks = 10'h008;
    endcase
  endfunction : sh_clocks

  // Divider terminal count, reserved codes take the slowest rate
  function automatic logic [3:0] div_limit(input logic [2:0] code);
    case (code)
      DIV_CODE_1: div_limit = 4'h0;
      DIV_CODE_2: div_limit = 4'h1;
      DIV_CODE_4: div_limit = 4'h3;
      DIV_CODE_8: div_limit = 4'h7;
      default: div_limit = 4'hF;
    endcase
  endfunction : div_limit

endpackage : adcctl_pkg

// ---- rtl/adcctl_clkdiv.sv ----
// Conversion clock as a one-cycle tick of the source clock
module adcctl_clkdiv (
  input wire logic clock,
  input wire logic reset,
  input wire logic restart,
  input wire logic [2:0] div_sel,
  output logic tick
);

  typedef struct packed {
    logic [3:0] cnt;
  } adcctl_div_t;

  adcctl_div_t s_q;
  adcctl_div_t s_d;
  logic [3:0] limit;

  // Count source clocks up to the terminal value
  always_comb begin
    limit = adcctl_pkg::div_limit(div_sel);
    s_d = s_q;
    tick = (s_q.cnt == limit) && !restart;
    if (restart || s_q.cnt >= limit) begin
      s_d.cnt = 4'h0;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : adcctl_clkdiv

// ---- rtl/adcctl_interval.sv ----
// Counts completions and decides which raise the conversion interrupt
module adcctl_interval (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic done,
  input wire logic enable,
  input wire logic [1:0] interval,
  output logic fire
);

  typedef struct packed {
    logic [2:0] cnt;
  } adcctl_itv_t;

  adcctl_itv_t s_q;
  adcctl_itv_t s_d;
  logic [2:0] last;

  // Every completion fires unless fixed-channel repeat is on with a 4 or 8 interval
  always_comb begin
    s_d = s_q;
    case (interval)
      adcctl_pkg::ITV_EVERY_4: last = 3'h3;
      adcctl_pkg::ITV_EVERY_8: last = 3'h7;
      default: last = 3'h0;
    endcase
    fire = done && (!enable || s_q.cnt >= last);
    if (clear) begin
      s_d.cnt = 3'h0;
    end else if (done && enable) begin
      s_d.cnt = (s_q.cnt >= last) ? 3'h0 : s_q.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : adcctl_interval

// ---- sim/adcctl_top_chk.sv ----
module adcctl_top_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic sample_hold_active,
  input wire logic sar_active,
  input wire logic conversion_end,
  input wire logic scan_mode,
  input wire logic repeat_mode,
  input wire logic reference_power_on
);
  logic [15:0] len_q;
  logic rd_done;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // Cycles since the sample phase began
  always_ff @(posedge clock) begin
    if (reset) len_q <= 16'h0000;
    else if ($rose(sample_hold_active)) len_q <= 16'h0001;
    else len_q <= len_q + 16'h0001;
  end
  // Read completing this cycle
  assign rd_done = avs_read && !avs_waitrequest;
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  a_phase_excl: assert property (!(sample_hold_active && sar_active))
    else $error("sample and approximation phases overlap");
  a_sample_then_sar: assert property ($fell(sample_hold_active) |-> sar_active)
    else $error("approximation did not follow sample phase");
  a_end_after_sar: assert property (conversion_end |-> $past(sar_active))
    else $error("completion without approximation phase");
  a_min_length: assert property (conversion_end |-> len_q >= 16'h002E)
    else $error("conversion shorter than minimum");
  a_single_stops: assert property (conversion_end && !repeat_mode |=> (!sample_hold_active)[*3])
    else $error("single mode started another conversion");
  a_repeat_goes: assert property (conversion_end && repeat_mode |-> ##[1:3] sample_hold_active)
    else $error("repeat mode did not continue");
  a_start_reads_0: assert property (rd_done && avs_address == adcctl_pkg::OFS_MODE0
    |-> !avs_readdata[0])
    else $error("start bit read back as one");
  a_trim_upper: assert property (rd_done && avs_address == adcctl_pkg::OFS_TRIM
    |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("trim upper bits not zero");
  a_busy_reads: assert property (rd_done && avs_address == adcctl_pkg::OFS_MODE0
    && $past(sample_hold_active || sar_active) |-> avs_readdata[6])
    else $error("busy flag low during conversion");
  c_repeat: cover property (conversion_end && repeat_mode);
  c_irq: cover property ($rose(irq));
  c_sar: cover property ($rose(sar_active));
endmodule : adcctl_top_chk

bind adcctl_top adcctl_top_chk chk (.clock, .reset, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
  .sample_hold_active, .sar_active, .conversion_end, .scan_mode, .repeat_mode,
  .reference_power_on);

// ---- sim/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic sample_hold_active, sar_active, conversion_end, scan_mode, repeat_mode, ref_on;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int num_errors, tests_run, sh, sr, k;
  typedef struct {logic [2:0] dv; logic [3:0] sc; int es; int ea;} adcctl_row_t;
  // Divider, sample code, expected sample and approximation cycles
  adcctl_row_t rows [9] = '{'{3'h0, 4'h8, 8, 38}, '{3'h1, 4'h9, 32, 76},
    '{3'h2, 4'hA, 96, 152}, '{3'h3, 4'hB, 256, 304}, '{3'h4, 4'h3, 1024, 608},
    '{3'h0, 4'hC, 128, 38}, '{3'h0, 4'hD, 512, 38}, '{3'h0, 4'h0, 8, 38},
    '{3'h7, 4'h8, 128, 608}};

  adcctl_top uut (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .sample_hold_active,
    .sar_active, .conversion_end, .scan_mode, .repeat_mode, .reference_power_on(ref_on));

  // Clock source
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(negedge clock);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) num_errors++;
      if (n > 20) give_verdict();
      @(negedge clock);
    end
    @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdchk

  // Measures both phases of one conversion, from the cycle after the start
  task automatic conv;
    int n;
    n = 0;
    sh = 0;
    sr = 0;
    @(negedge clock);
    while (conversion_end !== 1'b1 && n < 3000) begin
      if (sample_hold_active === 1'b1) sh++;
      if (sar_active === 1'b1) sr++;
      n++;
      @(negedge clock);
    end
    if (n >= 3000) num_errors++;
    if (n >= 3000) give_verdict();
  endtask : conv

  // Counts completions until the interrupt rises
  task automatic irqwait;
    int n;
    n = 0;
    k = 0;
    do begin
      @(negedge clock);
      if (conversion_end) k++;
      n++;
    end while (irq !== 1'b1 && n < 5000);
    if (n >= 5000) num_errors++;
    if (n >= 5000) give_verdict();
  endtask : irqwait

  // Stops repeat and waits until idle
  task automatic halt;
    int n;
    n = 0;
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_0000);
    do begin
      @(negedge clock);
      n++;
    end while ((sample_hold_active | sar_active) !== 1'b0 && n < 3000);
    if (n >= 3000) num_errors++;
    if (n >= 3000) give_verdict();
  endtask : halt

  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    num_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rdchk(adcctl_pkg::OFS_CLOCK, 32'h0000_0080);
    rdchk(adcctl_pkg::OFS_MODE0, 32'h0000_0000);
    bus(1'b1, adcctl_pkg::OFS_TRIM, 32'hFFFF_FF58);
    rdchk(adcctl_pkg::OFS_TRIM, 32'h0000_0058);
    rdchk(8'h30, 32'h0000_0000);
    // Reference supply on, then 3 us (120 cycles) before any start
    bus(1'b1, adcctl_pkg::OFS_MODE1, 32'h0000_0080);
    rdchk(adcctl_pkg::OFS_MODE1, 32'h0000_0080);
    chk(32'(ref_on), 32'h0000_0001);
    repeat (120) @(negedge clock);
    // Every divider and sample-hold code
    foreach (rows[i]) begin
      bus(1'b1, adcctl_pkg::OFS_CLOCK, {24'h00_0000, rows[i].sc, 1'b0, rows[i].dv});
      rdchk(adcctl_pkg::OFS_CLOCK, {24'h00_0000, rows[i].sc, 1'b0, rows[i].dv});
      bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_0001);
      conv();
      chk(sh, rows[i].es);
      chk(sr, rows[i].ea);
      rdchk(adcctl_pkg::OFS_MODE0, 32'h0000_0080);
      rdchk(adcctl_pkg::OFS_MODE0, 32'h0000_0000);
    end
    // Lane zero off: write ignored
    avs_byteenable <= 4'hE;
    bus(1'b1, adcctl_pkg::OFS_CLOCK, 32'h0000_0091);
    avs_byteenable <= 4'hF;
    rdchk(adcctl_pkg::OFS_CLOCK, 32'h0000_0087);
    bus(1'b1, adcctl_pkg::OFS_CLOCK, 32'h0000_0080);
    // Sticky status while masked, then cleared by read
    chk(32'(irq), 32'h0000_0000);
    rdchk(adcctl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rdchk(adcctl_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    bus(1'b1, adcctl_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    // Fixed-channel repeat, interrupt every fourth
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_000C);
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_000D);
    rdchk(adcctl_pkg::OFS_MODE0, 32'h0000_004C);
    chk(32'({scan_mode, repeat_mode}), 32'h0000_0001);
    irqwait();
    chk(k, 4);
    halt();
    rdchk(adcctl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    @(negedge clock);
    chk(32'(irq), 32'h0000_0000);
    // Scan repeat ignores the interval field
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_000E);
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_000F);
    chk(32'({scan_mode, repeat_mode}), 32'h0000_0003);
    irqwait();
    chk(k, 1);
    halt();
    rdchk(adcctl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    // Fixed-channel repeat, interrupt every eighth
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_0014);
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_0015);
    irqwait();
    chk(k, 8);
    halt();
    rdchk(adcctl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    // Writing start as zero launches nothing
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_0000);
    repeat (4) @(negedge clock);
    chk(32'(sample_hold_active), 32'h0000_0000);
    // Reset in mid conversion
    bus(1'b1, adcctl_pkg::OFS_MODE0, 32'h0000_0001);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdchk(adcctl_pkg::OFS_MODE0, 32'h0000_0000);
    chk(32'({sample_hold_active, sar_active, irq}), 32'h0000_0000);
    rdchk(adcctl_pkg::OFS_CLOCK, 32'h0000_0080);
    rdchk(adcctl_pkg::OFS_MODE1, 32'h0000_0000);
    give_verdict();
  end
endmodule : tb_top
